// [core/teoc_core.sv]
// Talker and listener end-of-string control with hold-off and interrupts
// Functional notes
// - End flag set on EOI, independent of data handshake.
// - End and byte-in flags raise separately maskable interrupts.
// - Force-end bit 5 of aux command drives EOI low in TACS.
// - Force-end bit self-clears one cycle later; pending end retained.
// - EOI stays asserted in TACS until next byte sent and accepted.
// - Force-end written outside TACS asserts EOI on next TACS; reset only cancels.
// - Byte-out set when byte accepted in TACS regardless of EOI.
// - ATN asserted leaves TACS, clears byte-out, stays out meanwhile.
// - Own listen, other talk or untalk send device to talker idle.
// - Own talk readdress: byte-out clear under ATN, set after release.
// - Command hold-off bit holds acceptor handshake on any command byte.
// - Attention bit in address status reflects ATN line.
// - Writing 0x10 clears hold-off and, if a command is held, pulses release to free it.
// - Byte-out mask clear prevents byte-out interrupt.
// - IRQ on rising OR of masked flags; status read releases it.
// - Byte-out set while in TACS and data output register empty.
`timescale 1ns/1ps
`default_nettype none
`include "teoc_defines.svh"
module teoc_core
  import teoc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Host side
  input  wire logic         aux_wr,
  input  wire logic [7:0]   aux_data,
  input  wire logic         data_out_wr,
  input  wire logic         data_in_rd,
  input  wire logic         status_rd,
  input  wire logic [2:0]   int_mask,
  output logic [7:0]        aux_command_register,
  output teoc_status_t      interrupt_status_register,
  output logic              address_status_atn,
  output logic              talker_active,
  output logic              irq_b,
  // Instrument bus side
  input  wire logic         atn_b_pin,
  input  wire logic         eoi_b_pin,
  input  wire logic         byte_accepted,
  input  wire logic         byte_received,
  input  wire teoc_cmd_t    cmd,
  output logic              eoi_b_oe,
  output logic              cmd_hold,
  output logic              cmd_release
);
  logic [2:0]   atn_sync;
  logic [2:0]   eoi_sync;
  logic         atn;
  logic         eoi;
  teoc_talk_t   talk;
  teoc_talk_t   next_talk;
  logic         end_pending;
  logic         out_full;
  logic         held;
  logic         irq_or_d;
  logic         irq_act;
  teoc_status_t st;

  // Three-stage input filters; change counted when last two agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      atn_sync <= `TEOC_SYNC_RST;
      eoi_sync <= `TEOC_SYNC_RST;
      atn      <= 1'b0;
      eoi      <= 1'b0;
    end else begin
      atn_sync <= {atn_sync[1:0], ~atn_b_pin};
      eoi_sync <= {eoi_sync[1:0], ~eoi_b_pin};
      if (atn_sync[1] == atn_sync[2]) atn <= atn_sync[2];
      if (eoi_sync[1] == eoi_sync[2]) eoi <= eoi_sync[2];
    end
  end

  // Talker active decode, shared by byte-sent, flag and pin logic
  function automatic logic is_active(input teoc_talk_t s);
    return s == TEOC_TACS;
  endfunction : is_active

  wire wr_feoi    = aux_wr && aux_data[`TEOC_AUX_FEOI_BIT];
  wire wr_release = aux_wr && (aux_data == `TEOC_AUX_RELEASE);
  wire untalked   = cmd.cmd_valid && (cmd.my_listen_addr || cmd.other_talk_addr || cmd.untalk);
  wire talk_addr  = cmd.cmd_valid && cmd.my_talk_addr;
  wire sent       = is_active(talk) && byte_accepted && out_full;
  // Command caught while hold-off set; a release write wins
  wire cmd_catch  = cmd.cmd_valid && aux_command_register[`TEOC_AUX_DACD_BIT] && !wr_release;

  // Talker state: ATN forces out of TACS; commands address or untalk
  always_comb begin
    next_talk = talk;
    if (untalked) next_talk = TEOC_TIDS;
    else if (talk_addr) next_talk = TEOC_TADS;
    else if (atn && talk == TEOC_TACS) next_talk = TEOC_TADS;
    else if (!atn && talk == TEOC_TADS) next_talk = TEOC_TACS;
  end

  wire       next_tacs = is_active(next_talk);
  wire [2:0] masked    = {st.end_flag & int_mask[`TEOC_MASK_END],
                          st.byte_in_flag & int_mask[`TEOC_MASK_BI],
                          st.byte_out_flag & int_mask[`TEOC_MASK_BO]};
  wire       irq_or = |masked;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      talk        <= TEOC_TIDS;
      end_pending <= 1'b0;
      out_full    <= 1'b0;
      held        <= 1'b0;
      cmd_release <= 1'b0;
      irq_or_d    <= 1'b0;
      irq_act     <= 1'b0;
      st          <= '0;
      aux_command_register <= `TEOC_AUX_RST;
    end else begin
      talk <= next_talk;
      // Force-end bit stored one cycle, then self-clears
      if (wr_release) aux_command_register <= `TEOC_AUX_RELEASE;
      else if (aux_wr) aux_command_register <= aux_data;
      else aux_command_register[`TEOC_AUX_FEOI_BIT] <= 1'b0;
      aux_command_register[`TEOC_AUX_DACR_BIT] <= 1'b0;
      cmd_release <= wr_release && held;
      if (wr_feoi) end_pending <= 1'b1;
      else if (sent) end_pending <= 1'b0;
      if (data_out_wr) out_full <= 1'b1;
      else if (sent) out_full <= 1'b0;
      if (cmd_catch) held <= 1'b1;
      else if (wr_release) held <= 1'b0;
      // End and byte-in flags: set wins over clear; for byte-out a data write wins
      if (eoi && !eoi_b_oe) st.end_flag <= 1'b1;
      else if (data_in_rd) st.end_flag <= 1'b0;
      if (byte_received) st.byte_in_flag <= 1'b1;
      else if (data_in_rd) st.byte_in_flag <= 1'b0;
      st.byte_out_flag <= next_tacs && !atn &&
                          ((!out_full || sent) && !data_out_wr);
      irq_or_d <= irq_or;
      if (irq_or && !irq_or_d) irq_act <= 1'b1;
      else if (status_rd) irq_act <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eoi_b_oe           <= 1'b0;
      cmd_hold           <= 1'b0;
      address_status_atn <= 1'b0;
      talker_active      <= 1'b0;
      irq_b              <= 1'b1;
      interrupt_status_register <= '0;
    end else begin
      eoi_b_oe <= next_tacs && (end_pending || wr_feoi) && !sent;
      cmd_hold <= held || cmd_catch;
      address_status_atn <= atn;
      talker_active      <= next_tacs;
      irq_b              <= ~((irq_or && !irq_or_d) || (irq_act && !status_rd));
      interrupt_status_register <= st;
    end
  end

  property p_eoi_tacs;
    @(posedge clk) disable iff (!rst_b) eoi_b_oe |-> $past(next_tacs);
  endproperty
  a_eoi_tacs: assert property (p_eoi_tacs) else $error("EOI outside TACS");
  property p_feoi_clear;
    @(posedge clk) disable iff (!rst_b)
      (aux_wr && aux_data[`TEOC_AUX_FEOI_BIT]) ##1 !aux_wr
      |=> !aux_command_register[`TEOC_AUX_FEOI_BIT];
  endproperty
  a_feoi_clear: assert property (p_feoi_clear) else $error("feoi stuck");
  property p_pending;
    @(posedge clk) disable iff (!rst_b) wr_feoi |=> end_pending;
  endproperty
  a_pending: assert property (p_pending) else $error("pending end lost");
  property p_atn_bo;
    @(posedge clk) disable iff (!rst_b) atn |=> !st.byte_out_flag;
  endproperty
  a_atn_bo: assert property (p_atn_bo) else $error("byte-out under ATN");
  property p_untalk;
    @(posedge clk) disable iff (!rst_b) untalked |=> talk == TEOC_TIDS;
  endproperty
  a_untalk: assert property (p_untalk) else $error("not untalked");
  property p_atn_bit;
    @(posedge clk) disable iff (!rst_b) ##1 address_status_atn == $past(atn);
  endproperty
  a_atn_bit: assert property (p_atn_bit) else $error("ATN bit wrong");
  property p_rel;
    @(posedge clk) disable iff (!rst_b) (wr_release && held) |=> cmd_release && !held;
  endproperty
  a_rel: assert property (p_rel) else $error("release failed");
  property p_end;
    @(posedge clk) disable iff (!rst_b) (eoi && !eoi_b_oe) |=> st.end_flag;
  endproperty
  a_end: assert property (p_end) else $error("end flag missed");
  property p_mask;
    @(posedge clk) disable iff (!rst_b) (int_mask == 3'h0 && !irq_act) |=> irq_b;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_eoi_on;
    @(posedge clk) disable iff (!rst_b) (next_tacs && end_pending && !sent) |=> eoi_b_oe;
  endproperty
  a_eoi_on: assert property (p_eoi_on) else $error("pending end not driven");
  property p_eoi_off;
    @(posedge clk) disable iff (!rst_b) sent |=> !eoi_b_oe;
  endproperty
  a_eoi_off: assert property (p_eoi_off) else $error("EOI kept after byte");
  property p_bo_set;
    @(posedge clk) disable iff (!rst_b)
      (sent && next_tacs && !atn && !data_out_wr) |=> st.byte_out_flag;
  endproperty
  a_bo_set: assert property (p_bo_set) else $error("byte-out not set");
  property p_ta_atn;
    @(posedge clk) disable iff (!rst_b) atn |=> !talker_active;
  endproperty
  a_ta_atn: assert property (p_ta_atn) else $error("talker under ATN");
  property p_readdr;
    @(posedge clk) disable iff (!rst_b)
      (talk == TEOC_TADS && !atn && !untalked && !talk_addr) |=> talker_active;
  endproperty
  a_readdr: assert property (p_readdr) else $error("not active after ATN");
  property p_hold;
    @(posedge clk) disable iff (!rst_b) cmd_catch |=> cmd_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("command not held");
  property p_irq_rise;
    @(posedge clk) disable iff (!rst_b) (irq_or && !irq_or_d) |=> !irq_b;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq edge missed");
  c_eoi: cover property (@(posedge clk) disable iff (!rst_b) eoi_b_oe ##[1:20] !eoi_b_oe);
  c_rel: cover property (@(posedge clk) disable iff (!rst_b) cmd_hold ##[1:20] cmd_release);
  c_irq: cover property (@(posedge clk) disable iff (!rst_b) !irq_b);
endmodule : teoc_core
`default_nettype wire

// [core/teoc_defines.svh]
// Constants for the talker end-of-string control block
`ifndef TEOC_DEFINES_SVH
`define TEOC_DEFINES_SVH
`define TEOC_AUX_FEOI_BIT   5
`define TEOC_AUX_DACD_BIT   6
`define TEOC_AUX_DACR_BIT   4
`define TEOC_AUX_RELEASE    8'h10
`define TEOC_AUX_RST        8'h00
`define TEOC_SYNC_RST       3'h0
`define TEOC_MASK_END       2
`define TEOC_MASK_BI        1
`define TEOC_MASK_BO        0
`endif

// [core/teoc_pkg.sv]
// Types for the talker end-of-string control block
package teoc_pkg;
  typedef enum logic [1:0] {
    TEOC_TIDS,
    TEOC_TADS,
    TEOC_TACS
  } teoc_talk_t;

  typedef struct packed {
    logic end_flag;
    logic byte_in_flag;
    logic byte_out_flag;
  } teoc_status_t;

  typedef struct packed {
    logic cmd_valid;
    logic my_talk_addr;
    logic my_listen_addr;
    logic other_talk_addr;
    logic untalk;
  } teoc_cmd_t;
endpackage : teoc_pkg

// [sim/teoc_bus_model.sv]
// Controller and listener model facing the end-of-string block
`timescale 1ns/1ps
`default_nettype none
module teoc_bus_model
  import teoc_pkg::*;
(
  // Clock and hold-off status
  input  wire logic clk,
  input  wire logic cmd_hold,
  // Bus lines
  output logic      atn_b,
  output logic      eoi_drv,
  output logic      acc,
  output logic      rcv,
  output teoc_cmd_t cmd
);
  initial begin
    atn_b      = 1'h1;
    eoi_drv    = 1'h0;
    {rcv, acc} = 2'h0;
    cmd        = '0;
  end
  task automatic set_atn(input logic v);
    // Attention kept low while the block holds the command, for up to 50 cycles
    for (int n = 0; n < 50 && v && cmd_hold; n++) @(posedge clk);
    @(posedge clk) atn_b <= v;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : set_atn
  task automatic send_cmd(input teoc_cmd_t c);
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : send_cmd
  task automatic set_eoi(input logic v);
    @(posedge clk) eoi_drv <= v;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : set_eoi
  task automatic pulse(input logic sel);
    @(posedge clk) {rcv, acc} <= sel ? 2'b10 : 2'b01;
    @(posedge clk) {rcv, acc} <= 2'b00;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : pulse
endmodule : teoc_bus_model
`default_nettype wire

// [sim/test_teoc_core.sv]
// Self-checking bench of the end-of-string block
`timescale 1ns/1ps
`default_nettype none
module test_teoc_core
  import teoc_pkg::*;
;
  logic clk = 1'b0, rel_seen = 1'b0;
  logic rst_b, aux_wr;
  logic [7:0] aux_data, acr;
  logic [2:0] hp, int_mask;
  logic atn, ta, irq_b, eoi_oe, hold, rel, atn_b, eoi_drv, acc, rcv;
  teoc_status_t isr;
  teoc_cmd_t cmd;
  int err_count = 0, checked = 0, cyc = 0;
  logic [15:0] rows [4] = '{16'h4040, 16'h6040, 16'h2000, 16'h0000};
  teoc_cmd_t untk [3] = '{5'h14, 5'h12, 5'h11};
  always #2.5 clk = ~clk;
  teoc_core uut (.clk(clk), .rst_b(rst_b), .aux_wr(aux_wr), .aux_data(aux_data),
    .data_out_wr(hp[2]), .data_in_rd(hp[1]), .status_rd(hp[0]), .int_mask(int_mask),
    .aux_command_register(acr), .interrupt_status_register(isr),
    .address_status_atn(atn), .talker_active(ta), .irq_b(irq_b), .atn_b_pin(atn_b),
    .eoi_b_pin(~(eoi_oe | eoi_drv)), .byte_accepted(acc), .byte_received(rcv),
    .cmd(cmd), .eoi_b_oe(eoi_oe), .cmd_hold(hold), .cmd_release(rel));
  teoc_bus_model bm (.clk(clk), .cmd_hold(hold), .atn_b(atn_b), .eoi_drv(eoi_drv),
    .acc(acc), .rcv(rcv), .cmd(cmd));
  always @(posedge clk) if (rel === 1'b1) rel_seen <= 1'b1;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr_aux(input logic [7:0] d);
    @(posedge clk) {aux_wr, aux_data} <= {1'b1, d};
    @(posedge clk) aux_wr <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : wr_aux
  task automatic host(input logic [2:0] v);
    @(posedge clk) hp <= v;
    @(posedge clk) hp <= 3'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : host
  task automatic address(input teoc_cmd_t c);
    bm.set_atn(1'b0);
    bm.send_cmd(c);
    bm.set_atn(1'b1);
  endtask : address
  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    {rst_b, aux_wr, aux_data, hp, int_mask} = '0;
    repeat (2) @(posedge clk);
    chk({acr, isr, irq_b, eoi_oe, ta}, 16'h0004, "reset outputs");
    chk(acr, 8'h00, "reset aux");
    chk({hold, rel, atn}, 16'h0000, "reset bus side");
    @(posedge clk) rst_b <= 1'b1;
    foreach (rows[i]) begin
      wr_aux(rows[i][15:8]);
      chk(acr, rows[i][7:0], "aux store");
    end
    wr_aux(8'h20);
    chk(eoi_oe, 1'b0, "eoi idle talker");
    bm.set_atn(1'b0);
    chk(atn, 1'b1, "atn bit");
    bm.send_cmd(5'h18);
    bm.set_atn(1'b1);
    chk({ta, eoi_oe, isr.byte_out_flag}, 3'h7, "late end");
    host(3'h4);
    chk(isr.byte_out_flag, 1'b0, "register full");
    bm.pulse(1'b0);
    chk({eoi_oe, isr.byte_out_flag, irq_b}, 3'h3, "byte sent");
    foreach (untk[i]) begin
      address(5'h18);
      chk(isr.byte_out_flag, 1'b1, "talk again");
      bm.set_atn(1'b0);
      chk({ta, isr.byte_out_flag}, 2'h0, "atn leaves talk");
      bm.send_cmd(untk[i]);
      bm.set_atn(1'b1);
      chk({ta, isr.byte_out_flag}, 2'h0, "untalked");
    end
    // Last byte: force-end and hold-off, byte, ATN seen, release, mask back
    address(5'h18);
    wr_aux(8'h60);
    host(3'h4);
    chk({eoi_oe, acr}, 16'h0140, "last byte armed");
    bm.pulse(1'b0);
    chk({eoi_oe, isr.byte_out_flag, irq_b}, 3'h3, "last byte sent");
    bm.set_atn(1'b0);
    bm.send_cmd(5'h11);
    chk({atn, hold, isr.byte_out_flag}, 3'h6, "hold off");
    wr_aux(8'h10);
    chk({rel_seen, hold, acr[6]}, 3'h4, "release");
    bm.set_atn(1'b1);
    chk({ta, isr.byte_out_flag}, 2'h0, "untalked after last");
    @(posedge clk) int_mask <= 3'h1;
    repeat (2) @(negedge clk);
    chk(irq_b, 1'b1, "no ghost");
    @(posedge clk) int_mask <= 3'h4;
    address(5'h14);
    bm.set_eoi(1'b1);
    chk({isr.end_flag, isr.byte_in_flag, irq_b}, 3'h4, "end ahead");
    host(3'h1);
    chk({isr.end_flag, irq_b}, 2'h3, "status read");
    bm.pulse(1'b1);
    chk(isr.byte_in_flag, 1'b1, "byte in");
    bm.set_eoi(1'b0);
    host(3'h2);
    @(posedge clk) int_mask <= 3'h0;
    bm.set_eoi(1'b1);
    chk({isr.end_flag, irq_b}, 2'h3, "end masked");
    bm.set_eoi(1'b0);
    wr_aux(8'h20);
    @(posedge clk) rst_b <= 1'b0;
    @(posedge clk) rst_b <= 1'b1;
    @(negedge clk);
    chk({acr, isr, irq_b, eoi_oe, ta}, 16'h0004, "reset again");
    address(5'h18);
    chk({ta, eoi_oe}, 2'h2, "pending end cancelled");
    complete_run();
  end
endmodule : test_teoc_core
`default_nettype wire
